// [core/iont_consts.vh]
// Purpose: constants for the pin chain connectivity test block
// Assumes: core clock 40 MHz from an internally multiplied 25 MHz reference
// Notes: strap code selecting the test mode is a plain default, not a known value
`ifndef IONT_CONSTS_VH
`define IONT_CONSTS_VH
`define IONT_CHAIN_LEN       42
`define IONT_REF_FREQ_MHZ    25
`define IONT_CORE_FREQ_MHZ   40
`define IONT_STRAP_W         3
`define IONT_STRAP_TEST_CODE 3'h7
`define IONT_IRQ_IDLE        1'b1
// strap settle counter: two edges fill the strap synchroniser after reset
`define IONT_SETTLE_W        2
`define IONT_SETTLE_LAST     2'h1
`define IONT_SETTLE_STEP     2'h1
`endif

// [core/iont_nand_tree.v]
// Purpose: board connectivity test chain of nested nand gates over the digital pins
// Assumes: straps are stable around reset; pins arrive unsynchronised from the board
// Notes: chain output is observed on the interrupt request pin while the test mode is on
// Overview of operation
// - in test mode each digital pin feeds one nand of a nested chain
// - last nand of the chain drives the interrupt request pin
// - chain output alternates with each new input pulled low
// - 25 MHz crystal reference is multiplied inside to clock the core
`include "iont_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module iont_nand_tree #(
	parameter CHAIN_LEN = `IONT_CHAIN_LEN
) (
	input  wire                     core_clk,
	input  wire                     nrst,
	input  wire                     indicator2_strap_bit1,
	input  wire                     indicator2_strap_bit0,
	input  wire                     indicator4_strap_bit0,
	input  wire [CHAIN_LEN-1:0]     chainPinIn,
	input  wire [CHAIN_LEN-1:0]     funcPinOut,
	input  wire [CHAIN_LEN-1:0]     funcPinOe,
	input  wire                     funcIrq_n,
	output wire [CHAIN_LEN-1:0]     chainPinOut,
	output wire [CHAIN_LEN-1:0]     chainPinOe,
	output reg                      interrupt_request_pin_out,
	output wire                     interrupt_request_pin_oe,
	output reg                      testMode_reg
);
	// core clock derives from the 25 MHz reference through the internal multiplier
	localparam integer REF_MHZ  = `IONT_REF_FREQ_MHZ;
	localparam integer CORE_MHZ = `IONT_CORE_FREQ_MHZ;

	// strap sampling states
	localparam [1:0] MODE_SETTLE = 2'h0;
	localparam [1:0] MODE_SAMPLE = 2'h1;
	localparam [1:0] MODE_HOLD   = 2'h2;

	// strap path
	reg  [`IONT_STRAP_W-1:0]  strapSync1_reg;
	reg  [`IONT_STRAP_W-1:0]  strapSync2_reg;
	wire [`IONT_STRAP_W-1:0]  strapRaw;
	wire                      strapIsTest;

	// mode state machine
	reg  [1:0]                modeState_reg;
	reg  [1:0]                modeState_next;
	reg  [`IONT_SETTLE_W-1:0] settleCnt_reg;
	reg  [`IONT_SETTLE_W-1:0] settleCnt_next;
	reg                       testMode_next;

	// pin path and chain
	reg  [CHAIN_LEN-1:0]      pinSync1_reg;
	reg  [CHAIN_LEN-1:0]      pinSync2_reg;
	wire [CHAIN_LEN:0]        chainNode;
	wire                      chainOut;

	// irq output path
	reg                       irqOut_next;

	// straps gathered in code order
	assign strapRaw = {indicator2_strap_bit1,
		indicator2_strap_bit0,
		indicator4_strap_bit0};

	// strap synchroniser, two stages
	always @(posedge core_clk) begin
		if (!nrst) begin
			strapSync1_reg <= {`IONT_STRAP_W{1'b0}};
			strapSync2_reg <= {`IONT_STRAP_W{1'b0}};
		end else begin
			strapSync1_reg <= strapRaw;
			strapSync2_reg <= strapSync1_reg;
		end
	end

	// only the second stage is decoded
	assign strapIsTest = (strapSync2_reg == `IONT_STRAP_TEST_CODE);

	// mode next state: settle, sample once, then hold until reset
	always @* begin
		modeState_next = modeState_reg;
		settleCnt_next = settleCnt_reg;
		testMode_next  = testMode_reg;
		case (modeState_reg)
			MODE_SETTLE: begin
				// second synchroniser stage still holds reset zeros here
				if (settleCnt_reg == `IONT_SETTLE_LAST) begin
					modeState_next = MODE_SAMPLE;
				end else begin
					settleCnt_next = settleCnt_reg + `IONT_SETTLE_STEP;
				end
			end
			MODE_SAMPLE: begin
				testMode_next  = strapIsTest;
				modeState_next = MODE_HOLD;
			end
			MODE_HOLD: begin
				// later strap changes ignored
				modeState_next = MODE_HOLD;
			end
			default: begin
				modeState_next = MODE_SETTLE;
				settleCnt_next = {`IONT_SETTLE_W{1'b0}};
				testMode_next  = 1'b0;
			end
		endcase
	end

	// mode registers
	always @(posedge core_clk) begin
		if (!nrst) begin
			modeState_reg <= MODE_SETTLE;
			settleCnt_reg <= {`IONT_SETTLE_W{1'b0}};
			testMode_reg  <= 1'b0;
		end else begin
			modeState_reg <= modeState_next;
			settleCnt_reg <= settleCnt_next;
			testMode_reg  <= testMode_next;
		end
	end

	// pin synchroniser, two stages
	always @(posedge core_clk) begin
		if (!nrst) begin
			pinSync1_reg <= {CHAIN_LEN{1'b0}};
			pinSync2_reg <= {CHAIN_LEN{1'b0}};
		end else begin
			pinSync1_reg <= chainPinIn;
			pinSync2_reg <= pinSync1_reg;
		end
	end

	// chain seed; first gate sees a constant high
	assign chainNode[0] = 1'b1;

	// per pin: one nand stage, pin direction and functional drive
	genvar i;
	generate
		for (i = 0; i < CHAIN_LEN; i = i + 1) begin : gChain
			// bit 0 is the first pin in test order
			assign chainNode[i+1] = ~(chainNode[i] & pinSync2_reg[i]);
			// pins become inputs in test mode
			assign chainPinOe[i]  = testMode_reg ? 1'b0 : funcPinOe[i];
			// functional level passes through untouched
			assign chainPinOut[i] = funcPinOut[i];
		end
	endgenerate

	// all high gives alternating output; with an even length the end is high
	assign chainOut = chainNode[CHAIN_LEN];

	// irq pin source: chain in test mode, else functional interrupt
	always @* begin
		if (testMode_reg) begin
			irqOut_next = chainOut;
		end else begin
			irqOut_next = funcIrq_n;
		end
	end

	// irq output register
	always @(posedge core_clk) begin
		if (!nrst) begin
			interrupt_request_pin_out <= `IONT_IRQ_IDLE;
		end else begin
			interrupt_request_pin_out <= irqOut_next;
		end
	end

	// driven actively in test mode; open drain low-only otherwise
	assign interrupt_request_pin_oe = testMode_reg | ~interrupt_request_pin_out;
endmodule
`default_nettype wire

// [bench/iont_monitor.sv]
// Purpose: chain checker
// Assumes: 3 cycle latency
// Notes: bound to block
`timescale 1ns/1ps
`default_nettype none
module iont_monitor #(
	parameter CHAIN_LEN = 42
) (
	input wire logic                 core_clk,
	input wire logic                 nrst,
	input wire logic                 testMode_reg,
	input wire logic                 funcIrq_n,
	input wire logic                 interrupt_request_pin_out,
	input wire logic                 interrupt_request_pin_oe,
	input wire logic [CHAIN_LEN-1:0] chainPinIn,
	input wire logic [CHAIN_LEN-1:0] funcPinOe,
	input wire logic [CHAIN_LEN-1:0] chainPinOe
);
	function automatic logic nt(input logic [CHAIN_LEN-1:0] p);
		nt = 1;
		for (int i = 0; i < CHAIN_LEN; i++) nt = ~(p[i] & nt);
	endfunction
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_run; testMode_reg && $past(testMode_reg, 3); endsequence
	property p_chain; s_run |-> interrupt_request_pin_out == nt($past(chainPinIn, 3)); endproperty
	a_chain: assert property (p_chain) else $error("bad chain");
	property p_tog; s_run ##0 $countones($past(chainPinIn, 3) ^ $past(chainPinIn, 4)) == 1
		|-> $changed(interrupt_request_pin_out); endproperty
	a_tog: assert property (p_tog) else $error("no toggle");
	property p_oe; testMode_reg |-> chainPinOe == '0 && interrupt_request_pin_oe; endproperty
	a_oe: assert property (p_oe) else $error("bad enables");
	sequence s_func; !testMode_reg && !$past(testMode_reg) && $past(nrst); endsequence
	property p_func; s_func |-> interrupt_request_pin_out == $past(funcIrq_n); endproperty
	a_func: assert property (p_func) else $error("irq not functional");
	property p_oeFunc; !testMode_reg |-> chainPinOe == funcPinOe
		&& interrupt_request_pin_oe == !interrupt_request_pin_out; endproperty
	a_oeFunc: assert property (p_oeFunc) else $error("bad functional enables");
endmodule
bind iont_nand_tree iont_monitor #(.CHAIN_LEN(CHAIN_LEN)) iont_monitor_inst (.core_clk, .nrst,
	.testMode_reg, .funcIrq_n, .interrupt_request_pin_out, .interrupt_request_pin_oe,
	.chainPinIn, .funcPinOe, .chainPinOe);
`default_nettype wire

// [bench/iont_board.sv]
// Purpose: board driver
// Assumes: bench sets low count
// Notes: low prefix from bit 0
`timescale 1ns/1ps
`default_nettype none
module iont_board (input wire logic [5:0] lowCount, output logic [41:0] pins);
	always_comb for (int i = 0; i < 42; i++) pins[i] = i >= lowCount;
endmodule
`default_nettype wire

// [bench/tb_iont_nand_tree.sv]
// Purpose: chain bench
// Assumes: straps high select test
// Notes: one more pin low per step
`timescale 1ns/1ps
`default_nettype none
module tb_iont_nand_tree;
	logic core_clk = 0, nrst = 0, s = 1, fi = 1, q, qe, tm;
	logic [5:0] k = 0;
	logic [41:0] p, oe, po, fo = 42'h2AAAAAAAAAA;
	int fails = 0, samples_checked = 0, cyc = 0;
	always #12.5 core_clk = ~core_clk;
	iont_board iont_board_inst (.lowCount(k), .pins(p));
	iont_nand_tree iont_nand_tree_inst (.core_clk, .nrst, .indicator2_strap_bit1(s),
		.indicator2_strap_bit0(s), .indicator4_strap_bit0(s), .chainPinIn(p), .funcPinOut(fo),
		.funcPinOe(fo), .funcIrq_n(fi), .chainPinOut(po), .chainPinOe(oe),
		.interrupt_request_pin_out(q), .interrupt_request_pin_oe(qe), .testMode_reg(tm));
	task chk(input logic [41:0] a, b);
		samples_checked++;
		if (a !== b) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, a, b);
		end
	endtask
	task finish_test;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task go(input logic m);
		nrst = 0;
		s = m;
		repeat (16) @(negedge core_clk);
		nrst = 1;
		repeat (6) @(negedge core_clk);
	endtask
	task walk;
		go(1);
		chk(q, 1);
		chk(oe, 0);
		chk(tm, 1);
		chk(qe, 1);
		chk(po, fo);
		for (int i = 1; i <= 42; i++) begin
			k = i[5:0];
			repeat (4) @(negedge core_clk);
			chk(q, !i[0]);
		end
	endtask
	task func;
		go(0);
		k = 3;
		fi = 0;
		repeat (3) @(negedge core_clk);
		chk(q, 0);
		chk(oe, fo);
		chk(tm, 0);
		chk(qe, 1);
		chk(po, fo);
	endtask
	always @(posedge core_clk) if (++cyc > 3000) begin fails++; finish_test; end
	initial begin walk; func; finish_test; end
endmodule
`default_nettype wire
